// ### shared/fpds_pkg.sv
// constants, types and helpers shared by both ends of the process-data link
// assumes one 10 MHz clock common to both ends
package fpds_pkg;

  // ****************************************
  // link geometry
  // ****************************************
  localparam int FPDS_WORD_W = 16;
  localparam int FPDS_MAX_WORDS = 10;
  localparam logic [3:0] FPDS_MAX_CNT = 4'ha;
  localparam logic [3:0] FPDS_CNT_RST = 4'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int FPDS_CLK_HZ = 10_000_000;
  localparam int FPDS_LOSS_UNIT_MS = 100;
  localparam int FPDS_LOSS_TICK_CYCLES = FPDS_CLK_HZ / 1000 * FPDS_LOSS_UNIT_MS;
  localparam int FPDS_TICK_W = 24;
  localparam logic [9:0] FPDS_DELAY_MIN = 10'h001;
  localparam logic [9:0] FPDS_DELAY_MAX = 10'h258;

  // ****************************************
  // loss reaction, word sources and sinks
  // ****************************************
  typedef enum logic [1:0] {
    FPDS_REACT_NONE   = 2'b00,
    FPDS_REACT_FAULT  = 2'b01,
    FPDS_REACT_FIXED7 = 2'b10,
    FPDS_REACT_HOLD   = 2'b11
  } fpds_react_t;

  typedef enum logic [2:0] {
    FPDS_DST_NONE   = 3'b000,
    FPDS_DST_CMD_LO = 3'b001,
    FPDS_DST_CMD_HI = 3'b010,
    FPDS_DST_REF1   = 3'b011,
    FPDS_DST_REF2   = 3'b100
  } fpds_dst_t;

  typedef enum logic [3:0] {
    FPDS_SRC_ZERO   = 4'h0,
    FPDS_SRC_STS_LO = 4'h1,
    FPDS_SRC_STS_HI = 4'h2,
    FPDS_SRC_ACT0   = 4'h3,
    FPDS_SRC_ACT1   = 4'h4,
    FPDS_SRC_ACT2   = 4'h5,
    FPDS_SRC_ALARM  = 4'h6,
    FPDS_SRC_ACODE  = 4'h7,
    FPDS_SRC_FLT0   = 4'h8,
    FPDS_SRC_FLT1   = 4'h9,
    FPDS_SRC_FLT2   = 4'ha
  } fpds_src_t;

  // ****************************************
  // alarm word and codes
  // ****************************************
  localparam int FPDS_ALM_CUR_LIM = 0;
  localparam int FPDS_ALM_OVERVOLT = 1;
  localparam int FPDS_ALM_UNDERVOLT = 2;
  localparam int FPDS_ALM_LINK = 4;
  localparam logic [15:0] FPDS_CODE_NONE = 16'h0000;
  localparam logic [15:0] FPDS_CODE_CUR_LIM = 16'h2001;
  localparam logic [15:0] FPDS_CODE_OVERVOLT = 16'h2002;
  localparam logic [15:0] FPDS_CODE_UNDERVOLT = 16'h2003;
  localparam logic [15:0] FPDS_CODE_LINK = 16'h2005;
  localparam int FPDS_CMD_RESET_BIT = 4;

  // ****************************************
  // controller register map (byte offsets)
  // ****************************************
  localparam logic [7:0] FPDS_REG_CTRL = 8'h00;
  localparam logic [7:0] FPDS_REG_STATUS = 8'h04;
  localparam logic [7:0] FPDS_REG_OUT_CNT = 8'h08;
  localparam logic [7:0] FPDS_REG_IN_CNT = 8'h0c;
  localparam logic [1:0] FPDS_REG_OUT_PAGE = 2'b01;
  localparam logic [1:0] FPDS_REG_IN_PAGE = 2'b10;

  typedef enum logic [1:0] {
    FPDS_CTL_IDLE = 2'b00,
    FPDS_CTL_SEND = 2'b01,
    FPDS_CTL_WAIT = 2'b10
  } fpds_ctl_st_t;

  // word count limited to 1..10
  function automatic logic [3:0] fpds_clamp_cnt(input logic [3:0] c);
    if (c == 4'h0) begin
      return 4'h1;
    end
    if (c > FPDS_MAX_CNT) begin
      return FPDS_MAX_CNT;
    end
    return c;
  endfunction : fpds_clamp_cnt

endpackage : fpds_pkg

// ### shared/fpds_if.sv
// word-serial process-data link between fieldbus controller and drive
// assumes both ends on the same clock; no back-pressure, one word per cycle
`timescale 1ns/100ps
interface fpds_if;
  import fpds_pkg::*;
  logic c2d_valid;
  logic c2d_last;
  logic [FPDS_WORD_W-1:0] c2d_data;
  logic d2c_valid;
  logic d2c_last;
  logic [FPDS_WORD_W-1:0] d2c_data;
  modport ctl (output c2d_valid, output c2d_last, output c2d_data,
               input d2c_valid, input d2c_last, input d2c_data);
  modport drv (input c2d_valid, input c2d_last, input c2d_data,
               output d2c_valid, output d2c_last, output d2c_data);
endinterface : fpds_if

// ### rtl/fpds_drive.sv
// drive end: process-data words, link-loss supervision, alarms, fault log
// assumes the controller end on the same clock; key and input resets are pins
// What this block does
// - selectable link loss reaction, four choices
// - loss reaction after 0.1 to 60.0 s delay
// - 16-bit words, up to ten, configured selection
// - command word drives operating state bits
// - drive returns state report word
// - references are signed 16-bit two's complement
// - drive returns 16-bit measured value words
// - wide profile makes command/state 32 bits
// - four-digit codes per alarm, readable on link
// - three-entry time-stamped fault history shifts
// - six-word operating snapshot at latest fault
// - fault reset sources; restart only cause gone
// - alarm bits 0,1,2; bits 0,1 gated
// - link break alarm bit 4, reaction governed
`timescale 1ns/100ps
module fpds_drive
  import fpds_pkg::*;
#(
  parameter int TICK_CYCLES = FPDS_LOSS_TICK_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  fpds_if.drv fb,
  input wire logic WIDE_PROFILE,
  input wire logic [3:0] OUT_WORDS,
  input wire logic [3:0] IN_WORDS,
  input wire logic [FPDS_MAX_WORDS-1:0][2:0] OUT_SEL,
  input wire logic [FPDS_MAX_WORDS-1:0][3:0] IN_SEL,
  input wire logic [31:0] STATUS_WORD,
  input wire logic [2:0][15:0] ACT_VALUES,
  input wire logic [1:0] LOSS_REACTION,
  input wire logic [9:0] LOSS_DELAY,
  input wire logic CUR_LIM_ACTIVE,
  input wire logic OVERVOLT_ACTIVE,
  input wire logic UNDERVOLT_ACTIVE,
  input wire logic LIMIT_ALARM_EN,
  input wire logic FAULT_EVT,
  input wire logic [15:0] FAULT_CODE,
  input wire logic FAULT_CAUSE,
  input wire logic [5:0][15:0] OP_DATA,
  input wire logic [31:0] TIME_STAMP,
  input wire logic RESET_KEY,
  input wire logic RESET_DI,
  output logic [31:0] CMD_WORD,
  output logic signed [15:0] REF1,
  output logic signed [15:0] REF2,
  output logic RUN_FIXED7,
  output logic HOLD_LAST_SPEED,
  output logic FAULT_TRIPPED,
  output logic RESTART_OK,
  output logic [15:0] ALARM_WORD,
  output logic [15:0] ALARM_CODE,
  output logic [2:0][15:0] FAULT_LOG,
  output logic [2:0][31:0] FAULT_TIME,
  output logic [5:0][15:0] FAULT_SNAPSHOT
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0] cmd;
    logic [15:0] ref1;
    logic [15:0] ref2;
    logic [3:0] rx_idx;
    logic tx_act;
    logic [3:0] tx_idx;
    logic d2c_valid;
    logic d2c_last;
    logic [15:0] d2c_data;
    logic [FPDS_TICK_W-1:0] tick;
    logic [9:0] tenth;
    logic lost;
    logic fixed7;
    logic hold;
    logic tripped;
    logic restart_ok;
    logic [15:0] alarm;
    logic [15:0] acode;
    logic [2:0][15:0] flog;
    logic [2:0][31:0] ftime;
    logic [5:0][15:0] snap;
    logic [1:0] key_s;
    logic [1:0] di_s;
  } fpds_drv_t;

  fpds_drv_t s_q;
  fpds_drv_t s_d;
  logic frame_end;
  logic loss_evt;
  logic record;
  logic reset_req;
  logic link_trip;
  logic [3:0] out_n;
  logic [3:0] in_n;
  logic [9:0] delay;
  logic [15:0] tx_word;
  fpds_react_t react;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    tx_word = 16'h0000;
    loss_evt = 1'b0;
    react = fpds_react_t'(LOSS_REACTION);
    out_n = fpds_clamp_cnt(OUT_WORDS);
    in_n = fpds_clamp_cnt(IN_WORDS);
    delay = LOSS_DELAY;
    if (delay < FPDS_DELAY_MIN) begin
      delay = FPDS_DELAY_MIN;
    end
    if (delay > FPDS_DELAY_MAX) begin
      delay = FPDS_DELAY_MAX;
    end
    s_d.key_s = {s_q.key_s[0], RESET_KEY};
    s_d.di_s = {s_q.di_s[0], RESET_DI};
    s_d.d2c_valid = 1'b0;
    s_d.d2c_last = 1'b0;
    frame_end = fb.c2d_valid && fb.c2d_last;

    // receive words into configured sinks
    if (fb.c2d_valid) begin
      if (s_q.rx_idx < out_n) begin
        case (fpds_dst_t'(OUT_SEL[s_q.rx_idx]))
          FPDS_DST_CMD_LO: s_d.cmd[15:0] = fb.c2d_data;
          FPDS_DST_CMD_HI: s_d.cmd[31:16] = fb.c2d_data;
          FPDS_DST_REF1: s_d.ref1 = fb.c2d_data;
          FPDS_DST_REF2: s_d.ref2 = fb.c2d_data;
          default: s_d.cmd = s_d.cmd;
        endcase
      end
      if (fb.c2d_last) begin
        s_d.rx_idx = 4'h0;
      end else if (s_q.rx_idx < FPDS_MAX_CNT) begin
        s_d.rx_idx = s_q.rx_idx + 4'h1;
      end
    end
    if (!WIDE_PROFILE) begin
      s_d.cmd[31:16] = 16'h0000;
    end

    // link-loss delay timer in 0.1 s steps
    if (frame_end) begin
      s_d.tick = '0;
      s_d.tenth = 10'h000;
      s_d.lost = 1'b0;
    end else if (!s_q.lost) begin
      if (s_q.tick == FPDS_TICK_W'(TICK_CYCLES - 1)) begin
        s_d.tick = '0;
        if (10'(s_q.tenth + 10'h001) >= delay) begin
          s_d.lost = 1'b1;
          loss_evt = 1'b1;
        end else begin
          s_d.tenth = 10'(s_q.tenth + 10'h001);
        end
      end else begin
        s_d.tick = FPDS_TICK_W'(s_q.tick + 1'b1);
      end
    end
    s_d.fixed7 = s_d.lost && (react == FPDS_REACT_FIXED7);
    s_d.hold = s_d.lost && (react == FPDS_REACT_HOLD);
    link_trip = s_d.lost && (react == FPDS_REACT_FAULT);

    // fault latch and history; a new fault wins over a reset
    record = FAULT_EVT || (loss_evt && react == FPDS_REACT_FAULT);
    reset_req = s_q.key_s[1] || s_q.di_s[1] || s_q.cmd[FPDS_CMD_RESET_BIT];
    if (reset_req && !FAULT_CAUSE && !link_trip) begin
      s_d.tripped = 1'b0;
    end
    if (record) begin
      s_d.tripped = 1'b1;
      s_d.flog = {s_q.flog[1:0], (FAULT_EVT ? FAULT_CODE : FPDS_CODE_LINK)};
      s_d.ftime = {s_q.ftime[1:0], TIME_STAMP};
      s_d.snap = OP_DATA;
    end
    s_d.restart_ok = !s_d.tripped && !FAULT_CAUSE;

    // alarm word and highest-priority alarm code
    s_d.alarm = 16'h0000;
    s_d.alarm[FPDS_ALM_CUR_LIM] = CUR_LIM_ACTIVE && LIMIT_ALARM_EN;
    s_d.alarm[FPDS_ALM_OVERVOLT] = OVERVOLT_ACTIVE && LIMIT_ALARM_EN;
    s_d.alarm[FPDS_ALM_UNDERVOLT] = UNDERVOLT_ACTIVE;
    s_d.alarm[FPDS_ALM_LINK] = s_d.lost && (react != FPDS_REACT_NONE);
    if (s_d.alarm[FPDS_ALM_CUR_LIM]) begin
      s_d.acode = FPDS_CODE_CUR_LIM;
    end else if (s_d.alarm[FPDS_ALM_OVERVOLT]) begin
      s_d.acode = FPDS_CODE_OVERVOLT;
    end else if (s_d.alarm[FPDS_ALM_UNDERVOLT]) begin
      s_d.acode = FPDS_CODE_UNDERVOLT;
    end else if (s_d.alarm[FPDS_ALM_LINK]) begin
      s_d.acode = FPDS_CODE_LINK;
    end else begin
      s_d.acode = FPDS_CODE_NONE;
    end

    // reply frame from configured sources
    if (s_q.tx_act) begin
      case (fpds_src_t'(IN_SEL[s_q.tx_idx]))
        FPDS_SRC_STS_LO: tx_word = STATUS_WORD[15:0];
        FPDS_SRC_STS_HI: tx_word = WIDE_PROFILE ? STATUS_WORD[31:16] : 16'h0000;
        FPDS_SRC_ACT0: tx_word = ACT_VALUES[0];
        FPDS_SRC_ACT1: tx_word = ACT_VALUES[1];
        FPDS_SRC_ACT2: tx_word = ACT_VALUES[2];
        FPDS_SRC_ALARM: tx_word = s_q.alarm;
        FPDS_SRC_ACODE: tx_word = s_q.acode;
        FPDS_SRC_FLT0: tx_word = s_q.flog[0];
        FPDS_SRC_FLT1: tx_word = s_q.flog[1];
        FPDS_SRC_FLT2: tx_word = s_q.flog[2];
        default: tx_word = 16'h0000;
      endcase
      s_d.d2c_valid = 1'b1;
      s_d.d2c_data = tx_word;
      if (s_q.tx_idx == 4'(in_n - 4'h1)) begin
        s_d.d2c_last = 1'b1;
        s_d.tx_act = 1'b0;
        s_d.tx_idx = 4'h0;
      end else begin
        s_d.tx_idx = s_q.tx_idx + 4'h1;
      end
    end
    if (frame_end) begin
      s_d.tx_act = 1'b1;
      s_d.tx_idx = 4'h0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fb.d2c_valid = s_q.d2c_valid;
  assign fb.d2c_last = s_q.d2c_last;
  assign fb.d2c_data = s_q.d2c_data;
  assign CMD_WORD = s_q.cmd;
  assign REF1 = s_q.ref1;
  assign REF2 = s_q.ref2;
  assign RUN_FIXED7 = s_q.fixed7;
  assign HOLD_LAST_SPEED = s_q.hold;
  assign FAULT_TRIPPED = s_q.tripped;
  assign RESTART_OK = s_q.restart_ok;
  assign ALARM_WORD = s_q.alarm;
  assign ALARM_CODE = s_q.acode;
  assign FAULT_LOG = s_q.flog;
  assign FAULT_TIME = s_q.ftime;
  assign FAULT_SNAPSHOT = s_q.snap;

endmodule : fpds_drive

// ### rtl/fpds_ctl.sv
// controller end: software-driven frame exchange over an Avalon-MM slave
// assumes the drive end on the same clock answers every frame
`timescale 1ns/100ps
module fpds_ctl
  import fpds_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  fpds_if.ctl fb,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    fpds_ctl_st_t st;
    logic ack;
    logic [31:0] rdata;
    logic [3:0] out_cnt;
    logic [FPDS_MAX_WORDS-1:0][15:0] out_w;
    logic [FPDS_MAX_WORDS-1:0][15:0] in_w;
    logic [3:0] in_cnt;
    logic [3:0] idx;
    logic done;
    logic c2d_valid;
    logic c2d_last;
    logic [15:0] c2d_data;
  } fpds_ctl_t;

  fpds_ctl_t s_q;
  fpds_ctl_t s_d;
  logic req;
  logic wr_now;
  logic start;
  logic done_set;
  logic [3:0] widx;
  logic [1:0] page;
  logic [3:0] n_out;

  assign req = AVS_READ || AVS_WRITE;
  assign AVS_WAITREQUEST = req && !s_q.ack;
  assign widx = AVS_ADDRESS[5:2];
  assign page = AVS_ADDRESS[7:6];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    start = 1'b0;
    done_set = 1'b0;
    n_out = fpds_clamp_cnt(s_q.out_cnt);
    s_d.ack = req && !s_q.ack;
    wr_now = AVS_WRITE && s_q.ack;

    // read data captured in the wait cycle, stands in the answer cycle
    if (AVS_READ && !s_q.ack) begin
      s_d.rdata = 32'h0000_0000;
      if (AVS_ADDRESS == FPDS_REG_STATUS) begin
        s_d.rdata = {28'h0000000, 2'b00, s_q.done, s_q.st != FPDS_CTL_IDLE};
      end else if (AVS_ADDRESS == FPDS_REG_OUT_CNT) begin
        s_d.rdata = {28'h0000000, s_q.out_cnt};
      end else if (AVS_ADDRESS == FPDS_REG_IN_CNT) begin
        s_d.rdata = {28'h0000000, s_q.in_cnt};
      end else if (AVS_ADDRESS[1:0] == 2'b00 && widx < FPDS_MAX_CNT) begin
        if (page == FPDS_REG_OUT_PAGE) begin
          s_d.rdata = {16'h0000, s_q.out_w[widx]};
        end else if (page == FPDS_REG_IN_PAGE) begin
          s_d.rdata = {16'h0000, s_q.in_w[widx]};
        end
      end
    end

    // register writes take effect in the answer cycle
    if (wr_now && AVS_BYTEENABLE[0]) begin
      if (AVS_ADDRESS == FPDS_REG_CTRL) begin
        start = AVS_WRITEDATA[0];
      end else if (AVS_ADDRESS == FPDS_REG_STATUS && AVS_WRITEDATA[1]) begin
        s_d.done = 1'b0;
      end else if (AVS_ADDRESS == FPDS_REG_OUT_CNT) begin
        s_d.out_cnt = AVS_WRITEDATA[3:0];
      end else if (page == FPDS_REG_OUT_PAGE && AVS_ADDRESS[1:0] == 2'b00
                   && widx < FPDS_MAX_CNT) begin
        s_d.out_w[widx][7:0] = AVS_WRITEDATA[7:0];
      end
    end
    if (wr_now && AVS_BYTEENABLE[1] && page == FPDS_REG_OUT_PAGE
        && AVS_ADDRESS[1:0] == 2'b00 && widx < FPDS_MAX_CNT) begin
      s_d.out_w[widx][15:8] = AVS_WRITEDATA[15:8];
    end

    // frame sequencer
    s_d.c2d_valid = 1'b0;
    s_d.c2d_last = 1'b0;
    case (s_q.st)
      FPDS_CTL_IDLE: begin
        if (start) begin
          s_d.st = FPDS_CTL_SEND;
          s_d.idx = 4'h0;
          s_d.in_cnt = 4'h0;
        end
      end
      FPDS_CTL_SEND: begin
        s_d.c2d_valid = 1'b1;
        s_d.c2d_data = s_q.out_w[s_q.idx];
        if (s_q.idx == 4'(n_out - 4'h1)) begin
          s_d.c2d_last = 1'b1;
          s_d.st = FPDS_CTL_WAIT;
        end else begin
          s_d.idx = s_q.idx + 4'h1;
        end
      end
      FPDS_CTL_WAIT: begin
        if (fb.d2c_valid) begin
          if (s_q.in_cnt < FPDS_MAX_CNT) begin
            s_d.in_w[s_q.in_cnt] = fb.d2c_data;
            s_d.in_cnt = s_q.in_cnt + 4'h1;
          end
          if (fb.d2c_last) begin
            s_d.st = FPDS_CTL_IDLE;
            done_set = 1'b1;
          end
        end
      end
      default: s_d.st = FPDS_CTL_IDLE;
    endcase
    if (done_set) begin
      s_d.done = 1'b1;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0;
      s_q.out_cnt <= FPDS_CNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign fb.c2d_valid = s_q.c2d_valid;
  assign fb.c2d_last = s_q.c2d_last;
  assign fb.c2d_data = s_q.c2d_data;
  assign AVS_READDATA = s_q.rdata;

endmodule : fpds_ctl

// ### tb/fpds_link_sva.sv
// checker on the process-data link wires between controller end and drive end
// assumes the signals of one fpds_if instance, all sampled on SYS_CLK
`timescale 1ns/100ps
module fpds_link_sva
  import fpds_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic c2d_valid,
  input wire logic c2d_last,
  input wire logic [FPDS_WORD_W-1:0] c2d_data,
  input wire logic d2c_valid,
  input wire logic d2c_last,
  input wire logic [FPDS_WORD_W-1:0] d2c_data
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  // ****************************************
  // word counters within a frame
  // ****************************************
  logic [3:0] c_cnt_q;
  logic [3:0] d_cnt_q;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      c_cnt_q <= 4'h0;
      d_cnt_q <= 4'h0;
    end else begin
      if (c2d_valid) begin
        c_cnt_q <= c2d_last ? 4'h0 : c_cnt_q + 4'h1;
      end
      if (d2c_valid) begin
        d_cnt_q <= d2c_last ? 4'h0 : d_cnt_q + 4'h1;
      end
    end
  end

  // ****************************************
  // framing and ordering
  // ****************************************
  a_reply_gap: assert property (c2d_valid && c2d_last |-> ##1 !d2c_valid ##1 d2c_valid)
    else $error("reply does not start two cycles after frame end");
  a_reply_run: assert property (d2c_valid && !d2c_last |=> d2c_valid)
    else $error("gap inside reply frame");
  a_reply_len: assert property (d2c_valid |-> d_cnt_q < 4'ha)
    else $error("reply frame longer than ten words");
  a_cmd_len: assert property (c2d_valid |-> c_cnt_q < 4'ha)
    else $error("controller frame longer than ten words");
  a_cmd_run: assert property (c2d_valid && !c2d_last |=> c2d_valid)
    else $error("gap inside controller frame");
  a_last_marks: assert property (d2c_last |-> d2c_valid)
    else $error("reply last flag without a word");
  a_no_cross: assert property (d2c_valid |-> !c2d_valid)
    else $error("controller sends while reply runs");
  a_quiet_start: assert property ($rose(RST_B) |-> !c2d_valid && !d2c_valid)
    else $error("link busy right after reset");
  a_end_idle: assert property (d2c_valid && d2c_last |=> !d2c_valid [*3])
    else $error("reply words after frame end");
endmodule : fpds_link_sva

// ### tb/tb.sv
// testbench: controller end and drive end joined by one link, software over avalon
// assumes the loss tick shortened to 10 cycles and both ends on one clock
`timescale 1ns/100ps
module tb;
  import fpds_pkg::*;
  logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, status_word, time_stamp, cmd_word;
  logic wide, cur_lim, ovolt, uvolt, lim_en, flt_evt, flt_cause, rst_key, rst_di;
  logic [3:0] out_words, in_words;
  logic [FPDS_MAX_WORDS-1:0][2:0] out_sel;
  logic [FPDS_MAX_WORDS-1:0][3:0] in_sel;
  logic [2:0][15:0] act_values;
  logic [1:0] loss_reaction;
  logic [9:0] loss_delay;
  logic [15:0] fault_code, alarm_word, alarm_code;
  logic [5:0][15:0] op_data, snapshot;
  logic signed [15:0] ref1, ref2;
  logic run_fixed7, hold_last, tripped, restart_ok;
  logic [2:0][15:0] fault_log;
  logic [2:0][31:0] fault_time;
  logic [1:0] react_tbl [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic [3:0] alm_in [5] = '{4'b1001, 4'b0001, 4'b1010, 4'b0100, 4'b1111};
  logic [15:0] alm_w [5] = '{16'h1, 16'h0, 16'h2, 16'h4, 16'h7};
  logic [15:0] alm_c [5] = '{16'h2001, 16'h0, 16'h2002, 16'h2003, 16'h2001};
  int err_count, n_tests, r, k;

  fpds_if fb_if();
  fpds_ctl fpds_ctl_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .fb(fb_if),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));
  fpds_drive #(.TICK_CYCLES(10)) fpds_drive_inst (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .fb(fb_if), .WIDE_PROFILE(wide), .OUT_WORDS(out_words), .IN_WORDS(in_words),
    .OUT_SEL(out_sel), .IN_SEL(in_sel), .STATUS_WORD(status_word), .ACT_VALUES(act_values),
    .LOSS_REACTION(loss_reaction), .LOSS_DELAY(loss_delay), .CUR_LIM_ACTIVE(cur_lim),
    .OVERVOLT_ACTIVE(ovolt), .UNDERVOLT_ACTIVE(uvolt), .LIMIT_ALARM_EN(lim_en),
    .FAULT_EVT(flt_evt), .FAULT_CODE(fault_code), .FAULT_CAUSE(flt_cause), .OP_DATA(op_data),
    .TIME_STAMP(time_stamp), .RESET_KEY(rst_key), .RESET_DI(rst_di), .CMD_WORD(cmd_word),
    .REF1(ref1), .REF2(ref2), .RUN_FIXED7(run_fixed7), .HOLD_LAST_SPEED(hold_last),
    .FAULT_TRIPPED(tripped), .RESTART_OK(restart_ok), .ALARM_WORD(alarm_word),
    .ALARM_CODE(alarm_code), .FAULT_LOG(fault_log), .FAULT_TIME(fault_time),
    .FAULT_SNAPSHOT(snapshot));
  fpds_link_sva fpds_link_sva_inst (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .c2d_valid(fb_if.c2d_valid), .c2d_last(fb_if.c2d_last), .c2d_data(fb_if.c2d_data),
    .d2c_valid(fb_if.d2c_valid), .d2c_last(fb_if.d2c_last), .d2c_data(fb_if.d2c_data));

  always #50 sys_clk = ~sys_clk;

  // ****************************************
  // compare, close, bus tasks
  // ****************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // request held until waitrequest is seen low at a rising edge
  task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      err_count++;
      complete_run();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  // start one exchange, poll done, clear done
  task frame;
    int j;
    av(1'b1, FPDS_REG_CTRL, 32'h1);
    for (j = 0; j < 30; j++) begin
      av(1'b0, FPDS_REG_STATUS, 32'h0);
      if (rd[1] === 1'b1) break;
    end
    if (j == 30) begin
      err_count++;
      complete_run();
    end
    av(1'b1, FPDS_REG_STATUS, 32'h2);
  endtask : frame

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    sys_clk = 0; rst_b = 0; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
    wide = 1; cur_lim = 0; ovolt = 0; uvolt = 0; lim_en = 0; flt_evt = 0; flt_cause = 0;
    rst_key = 0; rst_di = 0; out_words = 4'h4; in_words = 4'ha; status_word = 32'h5a5ac3c3;
    act_values = {16'h3333, 16'h2222, 16'h1111}; loss_reaction = 0; loss_delay = 10'h008;
    fault_code = 0; time_stamp = 32'h1000;
    for (k = 0; k < 10; k++) begin
      out_sel[k] = (k < 4) ? 3'(k + 1) : 3'h0;
      in_sel[k] = 4'(k + 1);
    end
    for (k = 0; k < 6; k++) op_data[k] = 16'h0a00 + 16'(k);
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    av(1'b0, FPDS_REG_OUT_CNT, 0); chk(rd, 32'h2);
    av(1'b0, 8'h3c, 0); chk(rd, 32'h0);
    av(1'b1, FPDS_REG_OUT_CNT, 32'h4);
    av(1'b1, 8'h40, 32'h1201); av(1'b1, 8'h44, 32'habcd);
    av(1'b1, 8'h48, 32'hfc18); av(1'b1, 8'h4c, 32'h03e8);
    frame();
    chk(cmd_word, 32'habcd1201);
    chk({16'h0, ref1}, 32'hfc18);
    chk({16'h0, ref2}, 32'h03e8);
    av(1'b0, FPDS_REG_IN_CNT, 0); chk(rd, 32'ha);
    av(1'b0, 8'h80, 0); chk(rd, 32'hc3c3);
    av(1'b0, 8'h84, 0); chk(rd, 32'h5a5a);
    for (k = 0; k < 3; k++) begin
      av(1'b0, 8'h88 + 8'(4 * k), 0); chk(rd, {16'h0, act_values[k]});
    end
    wide <= 1'b0;
    frame();
    chk(cmd_word, 32'h00001201);
    av(1'b0, 8'h84, 0); chk(rd, 32'h0);
    // loss supervision, one pass per reaction
    for (r = 0; r < 4; r++) begin
      loss_reaction <= react_tbl[r];
      frame();
      repeat (25) @(posedge sys_clk);
      chk({run_fixed7, hold_last, tripped, alarm_word[4]}, 32'h0);
      repeat (60) @(posedge sys_clk);
      chk({run_fixed7, hold_last, tripped, alarm_word[4]}, {react_tbl[r] == 2'h2,
        react_tbl[r] == 2'h3, react_tbl[r] == 2'h1, react_tbl[r] != 2'h0});
      chk(alarm_code, (react_tbl[r] != 2'h0) ? 32'h2005 : 32'h0);
      frame();
      chk({run_fixed7, hold_last}, 32'h0);
    end
    loss_reaction <= 2'h0;
    chk(fault_log[0], 32'h2005);
    frame();
    // fault with cause present, then key reset
    fault_code <= 16'h7777; flt_evt <= 1'b1; flt_cause <= 1'b1; time_stamp <= 32'h2000;
    @(posedge sys_clk);
    flt_evt <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(fault_log[0], 32'h7777);
    chk(fault_log[1], 32'h2005);
    chk(fault_time[0], 32'h2000);
    for (k = 0; k < 6; k++) chk(snapshot[k], op_data[k]);
    rst_key <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({tripped, restart_ok}, 32'h2);
    flt_cause <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({tripped, restart_ok}, 32'h1);
    // let the synchronised reset level drain before the next fault
    rst_key <= 1'b0;
    repeat (2) @(posedge sys_clk);
    fault_code <= 16'h8888; flt_evt <= 1'b1;
    @(posedge sys_clk);
    flt_evt <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(tripped, 32'h1);
    rst_di <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(tripped, 32'h0);
    rst_di <= 1'b0;
    repeat (2) @(posedge sys_clk);
    fault_code <= 16'h9999; flt_evt <= 1'b1;
    @(posedge sys_clk);
    flt_evt <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(tripped, 32'h1);
    av(1'b1, 8'h40, 32'h1211);
    frame();
    chk(tripped, 32'h0);
    chk({fault_log[1], fault_log[2]}, 32'h88887777);
    // alarm table, also read back over the link
    for (k = 0; k < 5; k++) begin
      {lim_en, uvolt, ovolt, cur_lim} <= alm_in[k];
      repeat (3) @(posedge sys_clk);
      chk(alarm_word, alm_w[k]);
      chk(alarm_code, alm_c[k]);
      frame();
      av(1'b0, 8'h94, 0); chk(rd, {16'h0, alm_w[k]});
      av(1'b0, 8'h98, 0); chk(rd, {16'h0, alm_c[k]});
    end
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk(fault_log[0], 32'h0);
    complete_run();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    complete_run();
  end
endmodule : tb
